// File: rtl/stid_pkg.sv
// Types shared by the SRAM test port instruction decode block
package stid_pkg;
  // Serial path placed between test data in and out
  typedef enum logic [1:0] {
    STID_SEL_BYP,
    STID_SEL_BSR,
    STID_SEL_ID
  } stid_sel_e;
endpackage

// File: rtl/stid_regs.svh
// Constants for the SRAM test port instruction decode block
`ifndef STID_REGS_SVH
`define STID_REGS_SVH

// ***************************************************
// Instruction register
// ***************************************************
`define STID_IR_W 3
`define STID_IR_CAPT 3'h1
`define STID_OP_EXTEST 3'h0
`define STID_OP_IDCODE 3'h1
`define STID_OP_SAMPLEZ 3'h2
`define STID_OP_RSV_A 3'h3
`define STID_OP_SAMPLE 3'h4
`define STID_OP_PRIV 3'h5
`define STID_OP_RSV_B 3'h6
`define STID_OP_BYPASS 3'h7

// ***************************************************
// Data registers and buffering
// ***************************************************
`define STID_ID_W 32
`define STID_ID_DEFAULT 32'h0000_0001
`define STID_BSR_W 8
`define STID_NOPIN_MASK 8'h80
`define STID_NOPIN_VALUE 8'hFF
`define STID_FIFO_DEPTH 32

`endif

// File: rtl/stid_top.sv
// Test port instruction decode, data registers and pin ring sampling path
// Operation
// - Code 111 puts bypass bit in path
// - Sample/preload captures pins, shifts boundary register
// - Pinless cells capture fixed default values
// - Code 000 decodes as external test
// - External test never gates functional inputs
// - External test drives boundary values on falling edge
// - External test captures pins; outputs follow cells
// - Code 001 captures and shifts identification
// - Reset loads identification instruction
// - Code 010 forces outputs high impedance
// - Codes 011, 110 behave as bypass
// - Codes read MSB leftmost, LSB rightmost
// - Only pin capture needs functional clock
// - Instruction register is three bits wide
// - Capture-IR loads 01 into low bits
// - New instruction effective only at Update-IR
// - Identification 32 bits, bit 0 first

`include "stid_regs.svh"

// ***************************************************
// Single clock FIFO for pin ring snapshots
// ***************************************************
module stid_fifo #(
  parameter int WIDTH = `STID_BSR_W,
  parameter int DEPTH = `STID_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(DEPTH);
  // Pointers carry one extra bit to tell full from empty
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic empty_w;
  logic full_w;
  // Pointer wrap only works for a power of two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
    $error("stid_fifo: depth must be a power of two, two or more");
  end
  assign empty_w = (wr_ptr_r == rd_ptr_r);
  assign full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign wr_ready_o = !full_w;
  assign rd_valid_o = !empty_w;
  assign rd_data_o = mem_r[rd_ptr_r[AW-1:0]];
  // Storage write, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (wr_valid_i && !full_w) begin
      mem_r[wr_ptr_r[AW-1:0]] <= wr_data_i;
    end
  end
  // Write pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
    end else if (wr_valid_i && !full_w) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end
  // Read pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ptr_r <= '0;
    end else if (rd_ready_i && !empty_w) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

// ***************************************************
// Top level
// ***************************************************
module stid_top #(
  parameter int BSR_W = `STID_BSR_W,
  parameter logic [`STID_BSR_W-1:0] NOPIN_MASK = `STID_NOPIN_MASK,
  parameter logic [`STID_BSR_W-1:0] NOPIN_VALUE = `STID_NOPIN_VALUE,
  // Arbitrary neutral identification value
  parameter logic [`STID_ID_W-1:0] ID_CODE = `STID_ID_DEFAULT,
  parameter int FIFO_DEPTH = `STID_FIFO_DEPTH
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic [BSR_W-1:0] PIN_RING_I,
  output logic SAMPLE_STALL_O,
  input wire logic TEST_CLK_I,
  input wire logic TAP_RESET_I,
  input wire logic TAP_CAPTURE_IR_I,
  input wire logic TAP_SHIFT_IR_I,
  input wire logic TAP_UPDATE_IR_I,
  input wire logic TAP_CAPTURE_DR_I,
  input wire logic TAP_SHIFT_DR_I,
  input wire logic TAP_UPDATE_DR_I,
  input wire logic TDI_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  output logic [`STID_IR_W-1:0] INSTR_O,
  output logic [BSR_W-1:0] PIN_DRV_O,
  output logic PIN_DRV_EN_O,
  output logic PIN_HIZ_O
);
  import stid_pkg::*;
  // Cell masks are sized for the default width only
  if (BSR_W != `STID_BSR_W || FIFO_DEPTH < 2) begin
    $error("stid_top: boundary width must match the cell masks");
  end

  // Instruction to serial path; reserved and private codes fall to bypass
  function automatic stid_sel_e sel_of(input logic [`STID_IR_W-1:0] op);
    case (op)
      `STID_OP_EXTEST: sel_of = STID_SEL_BSR;
      `STID_OP_SAMPLEZ, `STID_OP_SAMPLE: sel_of = STID_SEL_BSR;
      `STID_OP_IDCODE: sel_of = STID_SEL_ID;
      `STID_OP_RSV_A, `STID_OP_RSV_B: sel_of = STID_SEL_BYP;
      `STID_OP_PRIV: sel_of = STID_SEL_BYP;
      default: sel_of = STID_SEL_BYP;
    endcase
  endfunction

  // Capture image: pinless cells take their fixed value
  function automatic logic [BSR_W-1:0] ring_image(input logic [BSR_W-1:0] pins);
    ring_image = (pins & ~NOPIN_MASK) | (NOPIN_VALUE & NOPIN_MASK);
  endfunction

  // ***************************************************
  // Core domain: pin sampling into the FIFO
  // ***************************************************
  logic [BSR_W-1:0] pin_s1_r; // First synchroniser stage
  logic [BSR_W-1:0] pin_s2_r; // Stable pin levels
  logic fifo_wr_ready; // FIFO has room
  logic [BSR_W-1:0] fifo_rd_data; // Oldest snapshot
  logic fifo_rd_valid; // Snapshot waiting
  logic hs_idle; // Crossing free for a new word
  logic hs_req_r; // Toggle: new word offered
  logic [BSR_W-1:0] hs_dat_r; // Word held stable across the crossing
  logic ack_s1_r; // Acknowledge toggle, first stage
  logic ack_s2_r; // Acknowledge toggle, usable
  logic hs_seen_r; // Test side: last offer taken, read back as acknowledge

  // Pins are asynchronous to the core clock, so two stages first
  always_ff @(posedge CORE_CLK_I) begin
    pin_s1_r <= PIN_RING_I;
    pin_s2_r <= pin_s1_r;
  end

  // Functional inputs are only observed, never gated here
  stid_fifo #(
    .WIDTH(BSR_W),
    .DEPTH(FIFO_DEPTH)
  ) i_stid_fifo (
    .clk_i(CORE_CLK_I),
    .rst_i(SRST_I),
    .wr_data_i(pin_s2_r),
    .wr_valid_i(1'b1),
    .wr_ready_o(fifo_wr_ready),
    .rd_data_o(fifo_rd_data),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(hs_idle)
  );
  // Stalled test clock leaves the handshake busy and the FIFO fills
  assign hs_idle = (hs_req_r == ack_s2_r);

  // Offer the next snapshot to the test clock side
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      hs_req_r <= 1'b0;
      hs_dat_r <= ring_image('0);
    end else if (hs_idle && fifo_rd_valid) begin
      hs_req_r <= !hs_req_r;
      hs_dat_r <= fifo_rd_data;
    end
  end

  // Acknowledge toggle back from the test clock side
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= hs_seen_r;
      ack_s2_r <= ack_s1_r;
    end
  end
  // Full FIFO visible to the system as a stall flag
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      SAMPLE_STALL_O <= 1'b0;
    end else begin
      SAMPLE_STALL_O <= !fifo_wr_ready;
    end
  end

  // ***************************************************
  // Test clock domain: instruction and data registers
  // ***************************************************
  logic req_s1_r; // Offer toggle, first stage
  logic req_s2_r; // Offer toggle, usable
  logic [BSR_W-1:0] ring_r; // Latest pin ring image
  logic [`STID_IR_W-1:0] ir_sh_r; // Instruction shift stage
  logic [`STID_IR_W-1:0] ir_r; // Instruction in force
  logic byp_r; // Bypass bit
  logic [`STID_ID_W-1:0] id_sh_r; // Identification shift register
  logic [BSR_W-1:0] bsr_sh_r; // Boundary shift register
  stid_sel_e sel; // Path chosen by the instruction
  logic ser_bit; // Bit bound for the output pin

  assign sel = sel_of(ir_r);

  // Offer toggle crosses in; the word itself is stable by then
  always_ff @(posedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      req_s1_r <= hs_req_r;
      req_s2_r <= req_s1_r;
    end
  end

  // Take the offered word; only this path needs the core clock
  always_ff @(posedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      hs_seen_r <= 1'b0;
      ring_r <= ring_image('0);
    end else if (req_s2_r != hs_seen_r) begin
      hs_seen_r <= req_s2_r;
      ring_r <= hs_dat_r;
    end
  end

  // Instruction shift stage, least significant bit out first
  always_ff @(posedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      ir_sh_r <= `STID_IR_CAPT;
    end else if (TAP_CAPTURE_IR_I) begin
      ir_sh_r <= `STID_IR_CAPT;
    end else if (TAP_SHIFT_IR_I) begin
      ir_sh_r <= {TDI_I, ir_sh_r[`STID_IR_W-1:1]};
    end
  end

  // Instruction in force changes only at Update-IR or reset
  always_ff @(posedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      ir_r <= `STID_OP_IDCODE;
    end else if (TAP_UPDATE_IR_I) begin
      ir_r <= ir_sh_r;
    end
  end

  // Bypass bit captures zero, then passes data through
  always_ff @(posedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      byp_r <= 1'b0;
    end else if (TAP_CAPTURE_DR_I && sel == STID_SEL_BYP) begin
      byp_r <= 1'b0;
    end else if (TAP_SHIFT_DR_I && sel == STID_SEL_BYP) begin
      byp_r <= TDI_I;
    end
  end

  // Identification register, bit 0 reaches the output first
  always_ff @(posedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      id_sh_r <= ID_CODE;
    end else if (TAP_CAPTURE_DR_I && sel == STID_SEL_ID) begin
      id_sh_r <= ID_CODE;
    end else if (TAP_SHIFT_DR_I && sel == STID_SEL_ID) begin
      id_sh_r <= {TDI_I, id_sh_r[`STID_ID_W-1:1]};
    end
  end

  // Boundary register: parallel capture on the rising edge, then shift
  always_ff @(posedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      bsr_sh_r <= ring_image('0);
    end else if (TAP_CAPTURE_DR_I && sel == STID_SEL_BSR) begin
      bsr_sh_r <= ring_image(ring_r);
    end else if (TAP_SHIFT_DR_I && sel == STID_SEL_BSR) begin
      bsr_sh_r <= {TDI_I, bsr_sh_r[BSR_W-1:1]};
    end
  end

  // Serial output mux
  always_comb begin
    ser_bit = byp_r;
    if (TAP_SHIFT_IR_I) begin
      ser_bit = ir_sh_r[0];
    end else begin
      case (sel)
        STID_SEL_ID: ser_bit = id_sh_r[0];
        STID_SEL_BSR: ser_bit = bsr_sh_r[0];
        default: ser_bit = byp_r;
      endcase
    end
  end

  // ***************************************************
  // Falling edge outputs
  // ***************************************************
  // Output pin and enable change half a test clock after the shift edge
  always_ff @(negedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      TDO_O <= 1'b0;
      TDO_OE_O <= 1'b0;
    end else begin
      TDO_O <= ser_bit;
      TDO_OE_O <= TAP_SHIFT_IR_I || TAP_SHIFT_DR_I;
    end
  end
  // Update stage loads under preload or external test, driven under external test
  always_ff @(negedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      PIN_DRV_O <= '0;
    end else if (TAP_UPDATE_DR_I && (ir_r == `STID_OP_EXTEST || ir_r == `STID_OP_SAMPLE)) begin
      PIN_DRV_O <= bsr_sh_r;
    end
  end
  // Drive and high impedance modes follow the instruction in force
  always_ff @(negedge TEST_CLK_I) begin
    if (TAP_RESET_I) begin
      PIN_DRV_EN_O <= 1'b0;
      PIN_HIZ_O <= 1'b0;
      INSTR_O <= `STID_OP_IDCODE;
    end else begin
      PIN_DRV_EN_O <= (ir_r == `STID_OP_EXTEST);
      PIN_HIZ_O <= (ir_r == `STID_OP_SAMPLEZ);
      INSTR_O <= ir_r;
    end
  end
endmodule

// File: tb/stid_tap_host.sv
// Behavioural board test controller facing the test port
module stid_tap_host (
  output logic tck_o,
  output logic rst_o,
  output logic cir_o,
  output logic sir_o,
  output logic uir_o,
  output logic cdr_o,
  output logic sdr_o,
  output logic udr_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run = 1'b1;
  logic last;
  // ***************************************************
  // Test clock, parked low between frames
  // ***************************************************
  initial begin
    {rst_o, cir_o, sir_o, uir_o, cdr_o, sdr_o, udr_o} = 7'h40;
    tdi_o = 1'b1;
    tck_o = 1'b0;
    #3;
    forever begin
      #6;
      if (run || tck_o) begin
        tck_o = ~tck_o;
      end
    end
  end
  // One state per rise; output read before anything moves
  task automatic go(input logic [5:0] st, input logic d);
    @(posedge tck_o);
    last = tdo_i;
    {cir_o, sir_o, uir_o, cdr_o, sdr_o, udr_o} <= st;
    tdi_o <= d;
  endtask
  // Idle rises; input held at its pull-up level
  task automatic idle(input int n);
    run = 1'b1;
    repeat (n) go(6'h00, 1'b1);
    run = 1'b0;
  endtask
  // Capture, shift n bits LSB first, update
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = '0;
    run = 1'b1;
    go(ir ? 6'h20 : 6'h04, 1'b1);
    for (int i = 0; i < n; i++) begin
      go(ir ? 6'h10 : 6'h02, din[i]);
      if (i > 0) begin
        dout[i-1] = last;
      end
    end
    go(ir ? 6'h08 : 6'h01, 1'b1);
    dout[n-1] = last;
    idle(3);
  endtask
  // Test-Logic-Reset held over several rises
  task automatic reset();
    run = 1'b1;
    rst_o <= 1'b1;
    repeat (3) @(posedge tck_o);
    rst_o <= 1'b0;
    idle(2);
  endtask
endmodule

// File: tb/stid_top_props.sv
// Concurrent checks on the test port side of the instruction decode block
`include "stid_regs.svh"
// ***************************************************
// Checker
// ***************************************************
module stid_top_props #(
  parameter int BSR_W = `STID_BSR_W,
  parameter logic [`STID_ID_W-1:0] ID_CODE = `STID_ID_DEFAULT
) (
  input wire logic TEST_CLK_I,
  input wire logic TAP_RESET_I,
  input wire logic TAP_CAPTURE_IR_I,
  input wire logic TAP_SHIFT_IR_I,
  input wire logic TAP_UPDATE_IR_I,
  input wire logic TAP_CAPTURE_DR_I,
  input wire logic TAP_SHIFT_DR_I,
  input wire logic TAP_UPDATE_DR_I,
  input wire logic TDI_I,
  input wire logic TDO_O,
  input wire logic TDO_OE_O,
  input wire logic [`STID_IR_W-1:0] INSTR_O,
  input wire logic [BSR_W-1:0] PIN_DRV_O,
  input wire logic PIN_DRV_EN_O,
  input wire logic PIN_HIZ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // Default image of the pinless cells, bit-selectable
  localparam logic [`STID_BSR_W-1:0] NOPIN_V = `STID_NOPIN_VALUE;
  // All checks sit in the test clock domain
  default clocking cb @(posedge TEST_CLK_I); endclocking
  default disable iff (TAP_RESET_I);
  // Capture followed by the first shift
  sequence ir_start_s;
    TAP_CAPTURE_IR_I ##1 TAP_SHIFT_IR_I;
  endsequence
  sequence id_start_s;
    (TAP_CAPTURE_DR_I && INSTR_O == 3'h1) ##1 TAP_SHIFT_DR_I;
  endsequence
  // Pinless cell sits at the far end, seen after seven shifts
  sequence ring_walk_s;
    (TAP_CAPTURE_DR_I && INSTR_O inside {3'h0, 3'h2, 3'h4}) ##1 TAP_SHIFT_DR_I [*7];
  endsequence
  instr_update_a: assert property (!$stable(INSTR_O) |-> $past(TAP_UPDATE_IR_I))
    else $error("instruction changed without update");
  // Update register moves on the fall inside Update-DR, still sampled high at the next rise
  drive_update_a: assert property (!$stable(PIN_DRV_O) |-> TAP_UPDATE_DR_I)
    else $error("pin drive changed without update");
  drive_enable_a: assert property (PIN_DRV_EN_O == (INSTR_O == 3'h0))
    else $error("drive enable does not follow external test");
  hiz_force_a: assert property (PIN_HIZ_O == (INSTR_O == 3'h2))
    else $error("high impedance does not follow its code");
  bypass_path_a: assert property ($past(TAP_SHIFT_DR_I) && INSTR_O inside {3'h3, 3'h5, 3'h6, 3'h7}
    |-> TDO_O == $past(TDI_I))
    else $error("bypass bit not one stage");
  ir_capture_a: assert property (ir_start_s |-> TDO_O ##1 !TDO_O)
    else $error("instruction capture pattern wrong");
  id_first_a: assert property (id_start_s |-> TDO_O == ID_CODE[0] ##1 TDO_O == ID_CODE[1])
    else $error("identification not bit 0 first");
  nopin_cell_a: assert property (ring_walk_s |-> ##1 TDO_O == NOPIN_V[`STID_BSR_W-1])
    else $error("pinless cell not at default");
  // Serial output driven only across shift states
  oe_shift_window_a: assert property (TDO_OE_O == (TAP_SHIFT_IR_I || TAP_SHIFT_DR_I))
    else $error("serial output enable outside shift");
endmodule

bind stid_top stid_top_props #(.BSR_W(BSR_W), .ID_CODE(ID_CODE)) i_stid_top_props (
  .TEST_CLK_I(TEST_CLK_I),
  .TAP_RESET_I(TAP_RESET_I),
  .TAP_CAPTURE_IR_I(TAP_CAPTURE_IR_I),
  .TAP_SHIFT_IR_I(TAP_SHIFT_IR_I),
  .TAP_UPDATE_IR_I(TAP_UPDATE_IR_I),
  .TAP_CAPTURE_DR_I(TAP_CAPTURE_DR_I),
  .TAP_SHIFT_DR_I(TAP_SHIFT_DR_I),
  .TAP_UPDATE_DR_I(TAP_UPDATE_DR_I),
  .TDI_I(TDI_I),
  .TDO_O(TDO_O),
  .TDO_OE_O(TDO_OE_O),
  .INSTR_O(INSTR_O),
  .PIN_DRV_O(PIN_DRV_O),
  .PIN_DRV_EN_O(PIN_DRV_EN_O),
  .PIN_HIZ_O(PIN_HIZ_O)
);

// File: tb/tb_sram_tap_instruction_decode.sv
// Self-checking bench for the test port instruction decode block
`include "stid_regs.svh"
module tb_sram_tap_instruction_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, cen = 1'b1;
  logic [7:0] pins = 8'h00, drv, q;
  logic tck, trst, cir, sir, uir, cdr, sdr, udr, tdi, tdo, oe, stall, den, hiz;
  logic [2:0] instr;
  logic [31:0] rnd = 32'h19, o;
  logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
  int bad_count = 0, tests_run = 0;
  // ***************************************************
  // Clock, design and far side
  // ***************************************************
  initial begin
    forever begin
      #10;
      if (cen || clk) begin
        clk = ~clk;
      end
    end
  end
  stid_top i_stid_top (.CORE_CLK_I(clk), .SRST_I(srst), .PIN_RING_I(pins),
    .SAMPLE_STALL_O(stall), .TEST_CLK_I(tck), .TAP_RESET_I(trst),
    .TAP_CAPTURE_IR_I(cir), .TAP_SHIFT_IR_I(sir), .TAP_UPDATE_IR_I(uir),
    .TAP_CAPTURE_DR_I(cdr), .TAP_SHIFT_DR_I(sdr), .TAP_UPDATE_DR_I(udr),
    .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(oe), .INSTR_O(instr), .PIN_DRV_O(drv),
    .PIN_DRV_EN_O(den), .PIN_HIZ_O(hiz));
  stid_tap_host i_stid_tap_host (.tck_o(tck), .rst_o(trst), .cir_o(cir), .sir_o(sir),
    .uir_o(uir), .cdr_o(cdr), .sdr_o(sdr), .udr_o(udr), .tdi_o(tdi), .tdo_i(tdo));
  // ***************************************************
  // Model and compare helpers
  // ***************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Ring image as captured: pinless cells forced to default
  function automatic logic [31:0] img(input logic [7:0] p);
    return {24'h0, (p & ~`STID_NOPIN_MASK) | (`STID_NOPIN_VALUE & `STID_NOPIN_MASK)};
  endfunction
  task automatic chk_out(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_scan(input logic [31:0] e, input logic [31:0] g);
    chk_out("scan", e, g);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Load an instruction; old low bits show the capture pattern
  task automatic load_ir(input logic [2:0] c);
    i_stid_tap_host.scan(1'b1, 3, {29'h0, c}, o);
    chk_scan(32'h1, {30'h0, o[1:0]});
    chk_out("instr", {29'h0, c}, {29'h0, instr});
  endtask
  // New ring levels, then let the snapshot path settle
  task automatic set_pins();
    @(negedge clk);
    rnd = lfsr(rnd);
    pins <= rnd[7:0];
    i_stid_tap_host.idle(400);
  endtask
  // Boundary scan with fresh shift data kept in q
  task automatic ring_scan();
    rnd = lfsr(rnd);
    q = rnd[7:0];
    i_stid_tap_host.scan(1'b0, 8, {24'h0, q}, o);
  endtask
  // ***************************************************
  // Scenarios
  // ***************************************************
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (6) @(negedge clk);
    srst <= 1'b0;
    i_stid_tap_host.reset();
    chk_out("instr", 32'h1, {29'h0, instr});
    // Core clock stopped: test port must still work
    cen = 1'b0;
    i_stid_tap_host.scan(1'b0, 32, rnd, o);
    chk_scan(`STID_ID_DEFAULT, o);
    for (int k = 0; k < 4; k++) begin
      load_ir(codes[k]);
      rnd = lfsr(rnd);
      i_stid_tap_host.scan(1'b0, 8, rnd, o);
      chk_scan({24'h0, rnd[6:0], 1'b0}, o);
    end
    cen = 1'b1;
    load_ir(3'h4);
    set_pins();
    ring_scan();
    chk_scan(img(pins), o);
    chk_out("drive", {24'h0, q}, {24'h0, drv});
    chk_out("modes", 32'h0, {30'h0, den, hiz});
    load_ir(3'h0);
    chk_out("modes", 32'h2, {30'h0, den, hiz});
    chk_out("drive", {24'h0, q}, {24'h0, drv});
    set_pins();
    ring_scan();
    chk_scan(img(pins), o);
    chk_out("drive", {24'h0, q}, {24'h0, drv});
    load_ir(3'h2);
    chk_out("modes", 32'h1, {30'h0, den, hiz});
    set_pins();
    ring_scan();
    chk_scan(img(pins), o);
    // Test clock parked: snapshot buffer fills and refuses
    repeat (60) @(negedge clk);
    chk_out("stall", 32'h1, {31'h0, stall});
    srst <= 1'b1;
    repeat (2) @(negedge clk);
    chk_out("stall", 32'h0, {31'h0, stall});
    srst <= 1'b0;
    i_stid_tap_host.reset();
    chk_out("instr", 32'h1, {29'h0, instr});
    chk_out("modes", 32'h0, {30'h0, den, hiz});
    end_sim();
  end
endmodule
